// ==== rfs_pkg.sv ====
// constants, types and layout of the radio section fault supervision block
// How it works
// - while insertion is active, data out is replaced by all ones.
// - adaptation sink request is payload mismatch or alignment loss or alarm.
// - termination sink request is alarm, signal loss, trace mismatch, rx fail.
// - all-ones insertion starts at the next frame tick, within two frames.
// - all-ones insertion stops at the next frame tick, within two frames.
// - trail fail is alarm or signal loss or trace mismatch or rx fail.
// - with server-fail selected, server fail replaces alarm detection.
// - supervision mode: trail fail is server fail, not unequipped, or trace.
// - with server-fail selected, trail fail drives adaptation insertion; it always goes out for protection.
// - causes follow their expressions each cycle, no hysteresis.
// - rx loss cause needs no rx fail; rx fail cause is plain.
// - demod loss cause is demod loss without demod fail.
// - demod fail cause needs neither rx loss nor rx fail.
// - tx loss cause needs neither tx fail nor modulator fail.
// - tx fail cause is tx fail without modulator fail.
// - modulator loss cause excludes mod fail; mod fail cause is plain.
// - rx level below a threshold in a second flags that index.
// - with power control, tx level above threshold flags the second.
package rfs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int SEC_TIME_S = 1;
  localparam int SEC_CYCLES = SEC_TIME_S * CLK_HZ;
  localparam int SEC_W = 26;
  localparam int AIS_MAX_FRAMES = 2;
  localparam int PERSIST_FRAMES = 3;
  localparam int PERS_W = 8;
  localparam int LVL_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 5;
  localparam int N_RX_TH = 2;
  localparam int N_CAUSE = 8;
  localparam int N_CH = 2;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_RX_TH1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RX_TH2 = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_TX_TH1 = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_RX_CNT = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_TX_CNT = 5'h18;
  localparam int CTL_MON = 0;
  localparam int CTL_AUTO_TX_POWER_CONTROL = 1;
  localparam int CTL_SUPV = 2;
  localparam int CTL_SSF = 3;
  localparam int CTL_W = 4;
  localparam logic [CTL_W-1:0] CTRL_RST = 4'h1;
  localparam logic [LVL_W-1:0] RX_TH_RST = 8'h00;
  localparam logic [LVL_W-1:0] TX_TH_RST = 8'hff;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int ST_FAIL = 8;
  localparam int ST_AIS = 16;
  localparam int ST_TSF = 17;
  localparam int ST_INS = 18;
  localparam int CS_RXL = 0;
  localparam int CS_RXF = 1;
  localparam int CS_DML = 2;
  localparam int CS_DMF = 3;
  localparam int CS_TXL = 4;
  localparam int CS_TXF = 5;
  localparam int CS_MDL = 6;
  localparam int CS_MDF = 7;
  localparam int CH_SINK = 0;
  localparam int CH_SRC = 1;
  typedef enum logic {INS_PASS = 1'b0, INS_FORCE = 1'b1} rfs_ins_e;
endpackage : rfs_pkg

// ==== rfs_persist.sv ====
// persistency filter: output follows input after it differs for n frames
`timescale 1ns/10ps
module rfs_persist
  import rfs_pkg::*;
#(
  parameter int FRAMES = PERSIST_FRAMES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_pulse,
  input wire logic cause_in,
  output logic fail_out
);
  logic [PERS_W-1:0] cnt_reg;
  logic fail_reg;
  wire differ = cause_in != fail_reg;
  wire done = cnt_reg >= PERS_W'(FRAMES - 1);

  // a cause that flickers restarts the count, so brief glitches never show
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      fail_reg <= 1'b0;
    end else if (!differ) begin
      cnt_reg <= '0;
    end else if (frame_pulse) begin
      if (done) begin
        fail_reg <= cause_in;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + PERS_W'(1);
      end
    end
  end

  assign fail_out = fail_reg;
endmodule : rfs_persist

// ==== rfs_supervisor.sv ====
// fault supervision: all-ones insertion, trail fail, causes, level seconds
`timescale 1ns/10ps
module rfs_supervisor
  import rfs_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic frame_pulse,
  input wire logic payload_mismatch_defect,
  input wire logic alignment_loss_defect,
  input wire logic alarm_ind_defect,
  input wire logic unequipped_defect,
  input wire logic trace_mismatch_defect,
  input wire logic server_fail_in,
  input wire logic receiver_signal_loss,
  input wire logic demod_signal_loss,
  input wire logic receiver_fail,
  input wire logic demod_fail,
  input wire logic transmitter_signal_loss,
  input wire logic transmitter_fail,
  input wire logic modulator_signal_loss,
  input wire logic modulator_fail,
  input wire logic [LVL_W-1:0] received_level,
  input wire logic [LVL_W-1:0] transmitted_level,
  input wire logic [DATA_W-1:0] sink_data_in,
  output logic [DATA_W-1:0] sink_data_out,
  input wire logic [DATA_W-1:0] src_data_in,
  output logic [DATA_W-1:0] src_data_out,
  output logic all_ones_insert_request,
  output logic trail_fail_out,
  output logic [N_CAUSE-1:0] fault_cause,
  output logic [N_CAUSE-1:0] failure_out,
  output logic [N_RX_TH-1:0] rx_level_threshold_second,
  output logic tx_level_threshold_second
);
  function automatic logic [ADDR_W-1:0] reg_idx(input logic [31:0] a);
    reg_idx = {a[ADDR_W-1:2], 2'b00};
  endfunction : reg_idx

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a[31:ADDR_W] == '0) && (reg_idx(a) <= OFF_TX_CNT);
  endfunction : mapped

  logic [CTL_W-1:0] ctrl_reg;
  logic [LVL_W-1:0] rx_th_reg [N_RX_TH];
  logic [LVL_W-1:0] tx_th_reg;
  logic [CNT_W-1:0] rx_cnt_reg [N_RX_TH];
  logic [CNT_W-1:0] tx_cnt_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [31:0] awaddr_reg, wdata_reg;
  logic [3:0] wstrb_reg;
  logic [N_CAUSE-1:0] cause_reg;
  logic ais_reg, tsf_reg;

  wire mon_en = ctrl_reg[CTL_MON];
  wire auto_tx_power_control_en = ctrl_reg[CTL_AUTO_TX_POWER_CONTROL];
  wire supv_mode = ctrl_reg[CTL_SUPV];
  wire ssf_sel = ctrl_reg[CTL_SSF];

  // defect combination
  wire alarm_term = ssf_sel ? server_fail_in : alarm_ind_defect;
  wire sig_loss = receiver_signal_loss | demod_signal_loss;
  wire rx_fail = receiver_fail | demod_fail;
  wire tsf_norm = alarm_term | sig_loss | trace_mismatch_defect | rx_fail;
  wire tsf_supv = server_fail_in | ~unequipped_defect
                  | trace_mismatch_defect;
  wire tsf_next = supv_mode ? tsf_supv : tsf_norm;
  wire term_req = alarm_term | sig_loss | trace_mismatch_defect
                  | rx_fail;
  // without own alarm detection the adaptation sink takes trail fail
  wire adapt_alarm = ssf_sel ? tsf_reg : alarm_ind_defect;
  wire adapt_req = payload_mismatch_defect | alignment_loss_defect
                   | adapt_alarm;
  wire sink_req = term_req | adapt_req;
  wire src_req = server_fail_in;

  // correlated causes, re-evaluated every cycle
  logic [N_CAUSE-1:0] cause_next;
  assign cause_next[CS_RXL] = mon_en & receiver_signal_loss
                              & ~receiver_fail;
  assign cause_next[CS_RXF] = mon_en & receiver_fail;
  assign cause_next[CS_DML] = mon_en & demod_signal_loss
                              & ~demod_fail;
  assign cause_next[CS_DMF] = mon_en & demod_fail
                              & ~(receiver_signal_loss | receiver_fail);
  assign cause_next[CS_TXL] = mon_en & transmitter_signal_loss
                              & ~(transmitter_fail | modulator_fail);
  assign cause_next[CS_TXF] = mon_en & transmitter_fail
                              & ~modulator_fail;
  assign cause_next[CS_MDL] = mon_en & modulator_signal_loss
                              & ~modulator_fail;
  assign cause_next[CS_MDF] = mon_en & modulator_fail;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cause_reg <= '0;
      ais_reg <= 1'b0;
      tsf_reg <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      ais_reg <= sink_req;
      tsf_reg <= tsf_next;
    end
  end
  assign fault_cause = cause_reg;
  assign all_ones_insert_request = ais_reg;
  assign trail_fail_out = tsf_reg;

  genvar gi;
  generate
    for (gi = 0; gi < N_CAUSE; gi++) begin : g_persist
      rfs_persist #(.FRAMES(PERSIST_FRAMES)) u_persist (
        .ref_clk(ref_clk),
        .rst(rst),
        .frame_pulse(frame_pulse),
        .cause_in(cause_reg[gi]),
        .fail_out(failure_out[gi])
      );
    end
  endgenerate

  // insertion: state moves only on frame ticks, so within two frames
  rfs_ins_e ins_reg [N_CH];
  logic [DATA_W-1:0] dout_reg [N_CH];
  wire [N_CH-1:0] ch_req = {src_req, sink_req};
  wire [DATA_W-1:0] ch_din [N_CH];
  assign ch_din[CH_SINK] = sink_data_in;
  assign ch_din[CH_SRC] = src_data_in;
  generate
    for (gi = 0; gi < N_CH; gi++) begin : g_ins
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ins_reg[gi] <= INS_PASS;
        end else if (frame_pulse) begin
          case (ch_req[gi])
            1'b1: ins_reg[gi] <= INS_FORCE;
            1'b0: ins_reg[gi] <= INS_PASS;
            default: ins_reg[gi] <= INS_PASS;
          endcase
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          dout_reg[gi] <= '1;
        end else begin
          dout_reg[gi] <= (ins_reg[gi] == INS_FORCE) ? '1
                          : ch_din[gi];
        end
      end
    end
  endgenerate
  assign sink_data_out = dout_reg[CH_SINK];
  assign src_data_out = dout_reg[CH_SRC];

  // one-second intervals from the block clock
  logic [SEC_W-1:0] sec_cnt_reg;
  logic sec_tick_reg;
  logic [N_RX_TH-1:0] rx_hit_reg, rx_pls_reg;
  logic tx_hit_reg, tx_pls_reg;
  logic [N_RX_TH-1:0] rx_below;
  wire sec_end = sec_cnt_reg == SEC_W'(SEC_CNT - 1);
  wire tx_above = auto_tx_power_control_en & (transmitted_level > tx_th_reg);
  generate
    for (gi = 0; gi < N_RX_TH; gi++) begin : g_rxcmp
      assign rx_below[gi] = received_level < rx_th_reg[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sec_cnt_reg <= '0;
      sec_tick_reg <= 1'b0;
    end else begin
      sec_tick_reg <= sec_end;
      sec_cnt_reg <= sec_end ? '0 : sec_cnt_reg + SEC_W'(1);
    end
  end

  // a hit in the tick cycle, the first of the next second, is kept by restarting from the compare
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_hit_reg <= '0;
      tx_hit_reg <= 1'b0;
      rx_pls_reg <= '0;
      tx_pls_reg <= 1'b0;
    end else if (sec_tick_reg) begin
      rx_pls_reg <= rx_hit_reg;
      tx_pls_reg <= tx_hit_reg;
      rx_hit_reg <= rx_below;
      tx_hit_reg <= tx_above;
    end else begin
      rx_pls_reg <= '0;
      tx_pls_reg <= 1'b0;
      rx_hit_reg <= rx_hit_reg | rx_below;
      tx_hit_reg <= tx_hit_reg | tx_above;
    end
  end
  assign rx_level_threshold_second = rx_pls_reg;
  assign tx_level_threshold_second = tx_pls_reg;

  // axi4-lite write side
  logic awready_reg, wready_reg, bvalid_reg;
  logic [1:0] bresp_reg;
  wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire [ADDR_W-1:0] widx = reg_idx(awaddr_reg);
  wire wr_lo = do_write & wstrb_reg[0] & mapped(awaddr_reg);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else begin
      if (awready_reg) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (s_axi_awvalid && !aw_hold_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (wready_reg) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (s_axi_wvalid && !w_hold_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // thresholds rest at values that never flag until software loads them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
      rx_th_reg[0] <= RX_TH_RST;
      rx_th_reg[1] <= RX_TH_RST;
      tx_th_reg <= TX_TH_RST;
    end else if (wr_lo) begin
      if (widx == OFF_CTRL) ctrl_reg <= wdata_reg[CTL_W-1:0];
      if (widx == OFF_RX_TH1) rx_th_reg[0] <= wdata_reg[LVL_W-1:0];
      if (widx == OFF_RX_TH2) rx_th_reg[1] <= wdata_reg[LVL_W-1:0];
      if (widx == OFF_TX_TH1) tx_th_reg <= wdata_reg[LVL_W-1:0];
    end
  end

  // saturating second counters; a write to the counter word clears it
  wire clr_rx = wr_lo && widx == OFF_RX_CNT;
  wire clr_tx = wr_lo && widx == OFF_TX_CNT;
  generate
    for (gi = 0; gi < N_RX_TH; gi++) begin : g_rxcnt
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          rx_cnt_reg[gi] <= '0;
        end else if (rx_pls_reg[gi] && rx_cnt_reg[gi] != CNT_MAX) begin
          rx_cnt_reg[gi] <= clr_rx ? CNT_W'(1)
                            : rx_cnt_reg[gi] + CNT_W'(1);
        end else if (clr_rx) begin
          rx_cnt_reg[gi] <= '0;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_cnt_reg <= '0;
    end else if (tx_pls_reg && tx_cnt_reg != CNT_MAX) begin
      tx_cnt_reg <= clr_tx ? CNT_W'(1) : tx_cnt_reg + CNT_W'(1);
    end else if (clr_tx) begin
      tx_cnt_reg <= '0;
    end
  end

  // axi4-lite read side
  logic arready_reg, rvalid_reg;
  logic [31:0] araddr_reg, rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_mux;
  wire [ADDR_W-1:0] ridx = reg_idx(araddr_reg);
  always_comb begin
    rd_mux = '0;
    case (ridx)
      OFF_CTRL: rd_mux[CTL_W-1:0] = ctrl_reg;
      OFF_RX_TH1: rd_mux[LVL_W-1:0] = rx_th_reg[0];
      OFF_RX_TH2: rd_mux[LVL_W-1:0] = rx_th_reg[1];
      OFF_TX_TH1: rd_mux[LVL_W-1:0] = tx_th_reg;
      OFF_STATUS: rd_mux[ST_INS+N_CH-1:0] = {ins_reg[CH_SRC],
        ins_reg[CH_SINK], tsf_reg, ais_reg, failure_out, cause_reg};
      OFF_RX_CNT: rd_mux = {rx_cnt_reg[1], rx_cnt_reg[0]};
      OFF_TX_CNT: rd_mux[CNT_W-1:0] = tx_cnt_reg;
      default: rd_mux = '0;
    endcase
  end

  logic ar_hold_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
      ar_hold_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      araddr_reg <= '0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (arready_reg) begin
        arready_reg <= 1'b0;
        ar_hold_reg <= 1'b1;
        araddr_reg <= s_axi_araddr;
      end else if (s_axi_arvalid && !ar_hold_reg && !rvalid_reg) begin
        arready_reg <= 1'b1;
      end
      if (ar_hold_reg && !rvalid_reg) begin
        ar_hold_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= mapped(araddr_reg) ? rd_mux : '0;
        rresp_reg <= mapped(araddr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_req_at_frame;
    sink_req && frame_pulse;
  endsequence
  sequence s_forced_out;
    ins_reg[CH_SINK] == INS_FORCE ##1 sink_data_out == '1;
  endsequence
  property p_ins_start;
    s_req_at_frame |=> s_forced_out;
  endproperty
  a_ins_start: assert property (p_ins_start)
    else $error("insertion did not start at frame tick");
  property p_ins_stop;
    !sink_req && frame_pulse ##1 !frame_pulse |=>
      sink_data_out == $past(sink_data_in);
  endproperty
  a_ins_stop: assert property (p_ins_stop)
    else $error("insertion did not stop at frame tick");
  property p_ais_term;
    (rx_fail || trace_mismatch_defect) |=> all_ones_insert_request;
  endproperty
  a_ais_term: assert property (p_ais_term)
    else $error("termination request missing");
  property p_ais_adapt;
    (payload_mismatch_defect || alignment_loss_defect)
      |=> all_ones_insert_request;
  endproperty
  a_ais_adapt: assert property (p_ais_adapt)
    else $error("adaptation request missing");
  property p_tsf;
    (!supv_mode && sig_loss) || (supv_mode && !unequipped_defect)
      |=> trail_fail_out;
  endproperty
  a_tsf: assert property (p_tsf)
    else $error("trail fail missing");
  property p_rx_cause;
    mon_en && receiver_fail |=> fault_cause[CS_RXF]
      && !fault_cause[CS_RXL] && !fault_cause[CS_DMF];
  endproperty
  a_rx_cause: assert property (p_rx_cause)
    else $error("rx fail correlation wrong");
  property p_tx_cause;
    mon_en && modulator_fail |=> fault_cause[CS_MDF]
      && !fault_cause[CS_TXF] && !fault_cause[CS_TXL];
  endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("modulator fail correlation wrong");
  property p_mon_off;
    !mon_en |=> fault_cause == '0;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("cause raised while monitoring off");
  property p_rx_sec;
    sec_tick_reg && rx_hit_reg[0] |=> rx_level_threshold_second[0]
      ##1 !rx_level_threshold_second[0];
  endproperty
  a_rx_sec: assert property (p_rx_sec)
    else $error("rx level second not pulsed once");
  property p_tx_sec;
    !auto_tx_power_control_en && (sec_tick_reg || !tx_hit_reg) |=> !tx_hit_reg;
  endproperty
  a_tx_sec: assert property (p_tx_sec)
    else $error("tx level hit without power control");
endmodule : rfs_supervisor

// ==== rfs_detector_model.sv ====
// behavioural model of the radio defect detectors and the frame source
`timescale 1ns/10ps
module rfs_detector_model #(
  parameter int FRAME_CYC = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [13:0] cmd,
  output logic frame_pulse,
  output logic [13:0] dfct
);
  int cnt;
  // detector outputs are registered, so levels only move after an edge
  always_ff @(posedge ref_clk) begin
    dfct <= rst ? 14'h0000 : cmd;
    cnt <= (rst || cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
    frame_pulse <= !rst && cnt == FRAME_CYC - 1;
  end
endmodule : rfs_detector_model

// ==== rfs_supervisor_tb.sv ====
// self-checking bench for the radio section fault supervisor
`timescale 1ns/10ps
module rfs_supervisor_tb;
  import rfs_pkg::*;
  localparam int SEC = 20;
  localparam int FR = 6;
  logic ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_pulse;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [LVL_W-1:0] received_level, transmitted_level;
  logic [DATA_W-1:0] sink_data_in, sink_data_out, src_data_in, src_data_out;
  logic all_ones_insert_request, trail_fail_out, tx_level_threshold_second;
  logic [N_CAUSE-1:0] fault_cause, failure_out;
  logic [N_RX_TH-1:0] rx_level_threshold_second;
  logic [13:0] cmd, dfct;
  int fail_count, checks_done;
  // rows: defects, expected causes, then {tsf, request} in the low bits
  logic [23:0] rows [16] = '{24'h001013, 24'h003023, 24'h004043,
    24'h00c083, 24'h009013, 24'h010100, 24'h030200, 24'h090800,
    24'h0a0800, 24'h040400, 24'h0c0800, 24'h100001, 24'h200001,
    24'h400003, 24'h800003, 24'h000000};
  // mode rows: ctrl, unequipped, server fail, alarm, expected tsf
  logic [7:0] mt [5] = '{8'h58, 8'h51, 8'h5d, 8'h92, 8'h95};

  rfs_detector_model #(.FRAME_CYC(FR)) i_det (.ref_clk, .rst, .cmd,
    .frame_pulse, .dfct);
  rfs_supervisor #(.SEC_CNT(SEC)) i_dut (.*,
    .receiver_signal_loss(dfct[0]), .receiver_fail(dfct[1]),
    .demod_signal_loss(dfct[2]), .demod_fail(dfct[3]),
    .transmitter_signal_loss(dfct[4]), .transmitter_fail(dfct[5]),
    .modulator_signal_loss(dfct[6]), .modulator_fail(dfct[7]),
    .payload_mismatch_defect(dfct[8]), .alignment_loss_defect(dfct[9]),
    .alarm_ind_defect(dfct[10]), .trace_mismatch_defect(dfct[11]),
    .unequipped_defect(dfct[12]), .server_fail_in(dfct[13]));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic tmo(input int n);
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask : tmo

  // lines the bench up with the clock edge at which a second is counted
  task automatic wait_sec;
    int n;
    n = 0;
    while (rx_level_threshold_second[0] !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    tmo(n);
  endtask : wait_sec

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= 32'(a);
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= 32'(a);
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd

  // a miss here means the data path overran its two-frame allowance
  task automatic wait_out(input logic [7:0] e, input bit src);
    int n;
    n = 0;
    while ((src ? src_data_out : sink_data_out) !== e && n < 2*FR+4) begin
      @(posedge ref_clk);
      n++;
    end
    chk("data out", 32'(e), 32'(src ? src_data_out : sink_data_out));
  endtask : wait_out

  task automatic lvl(input logic [7:0] r, t, c, input int e0, e1, e2);
    int n0, n1, n2;
    wr(OFF_CTRL, 32'(c), 4'hf, RESP_OKAY);
    received_level <= r;
    transmitted_level <= t;
    // let any second that saw the old levels finish before counting
    repeat (SEC + 5) @(posedge ref_clk);
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (2*SEC) begin
      @(posedge ref_clk);
      n0 += (rx_level_threshold_second[0] === 1'b1);
      n1 += (rx_level_threshold_second[1] === 1'b1);
      n2 += (tx_level_threshold_second === 1'b1);
    end
    chk("rx1 seconds", 32'(e0), 32'(n0));
    chk("rx2 seconds", 32'(e1), 32'(n1));
    chk("tx seconds", 32'(e2), 32'(n2));
  endtask : lvl

  initial begin
    fail_count = 0;
    checks_done = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot} = 6'h00;
    s_axi_wstrb = 4'hf;
    cmd = 14'h0000;
    received_level = 8'h80;
    transmitted_level = 8'h80;
    sink_data_in = 8'h5a;
    src_data_in = 8'h3c;
    repeat (20) @(posedge ref_clk);
    chk("sink reset", 32'hff, 32'(sink_data_out));
    chk("cause reset", 32'h0, 32'(fault_cause | failure_out));
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h1, RESP_OKAY);
    rd(OFF_RX_TH1, 32'h0, RESP_OKAY);
    rd(OFF_RX_TH2, 32'h0, RESP_OKAY);
    rd(OFF_TX_TH1, 32'hff, RESP_OKAY);
    rd(OFF_RX_CNT, 32'h0, RESP_OKAY);
    rd(5'h1c, 32'h0, RESP_SLVERR);
    wr(5'h1c, 32'h1, 4'hf, RESP_SLVERR);
    wr(OFF_TX_TH1, 32'h12, 4'h0, RESP_OKAY);
    rd(OFF_TX_TH1, 32'hff, RESP_OKAY);
    foreach (rows[i]) begin
      cmd <= {2'b00, rows[i][23:12]};
      repeat (4) @(posedge ref_clk);
      chk("rx cause", 32'(rows[i][7:4]),
          32'(fault_cause[3:0]));
      chk("tx cause", 32'(rows[i][11:8]),
          32'(fault_cause[7:4]));
      chk("tsf", 32'(rows[i][1]), 32'(trail_fail_out));
      chk("request", 32'(rows[i][0]),
          32'(all_ones_insert_request));
    end
    foreach (mt[i]) begin
      wr(OFF_CTRL, 32'(mt[i][7:4]), 4'hf, RESP_OKAY);
      cmd <= {mt[i][2], mt[i][3], 1'b0, mt[i][1], 10'h000};
      repeat (4) @(posedge ref_clk);
      chk("mode tsf", 32'(mt[i][0]), 32'(trail_fail_out));
    end
    wr(OFF_CTRL, 32'h0, 4'hf, RESP_OKAY);
    cmd <= 14'h00ff;
    repeat (4) @(posedge ref_clk);
    chk("cause off", 32'h0, 32'(fault_cause));
    wr(OFF_CTRL, 32'h1, 4'hf, RESP_OKAY);
    repeat (4) @(posedge ref_clk);
    chk("cause on", 32'h82, 32'(fault_cause));
    repeat (4*FR + 4) @(posedge ref_clk);
    chk("failure", 32'h82, 32'(failure_out));
    rd(OFF_STATUS, 32'h00078282, RESP_OKAY);
    cmd <= 14'h0000;
    wait_out(8'h5a, 1'b0);
    cmd <= 14'h0800;
    wait_out(8'hff, 1'b0);
    cmd <= 14'h0000;
    wait_out(8'h5a, 1'b0);
    cmd <= 14'h2000;
    wait_out(8'hff, 1'b1);
    cmd <= 14'h0000;
    wait_out(8'h3c, 1'b1);
    wr(OFF_RX_TH1, 32'h40, 4'hf, RESP_OKAY);
    wr(OFF_RX_TH2, 32'h20, 4'hf, RESP_OKAY);
    wr(OFF_TX_TH1, 32'h80, 4'hf, RESP_OKAY);
    rd(OFF_RX_TH2, 32'h20, RESP_OKAY);
    lvl(8'h30, 8'h90, 8'h03, 2, 0, 2);
    // clear just after a counted second, so the read sees two whole seconds
    wait_sec();
    wr(OFF_RX_CNT, 32'h0, 4'hf, RESP_OKAY);
    wr(OFF_TX_CNT, 32'h0, 4'hf, RESP_OKAY);
    repeat (2*SEC - 8) @(posedge ref_clk);
    rd(OFF_RX_CNT, 32'h2, RESP_OKAY);
    rd(OFF_TX_CNT, 32'h2, RESP_OKAY);
    lvl(8'h10, 8'h80, 8'h03, 2, 2, 0);
    lvl(8'h40, 8'h90, 8'h01, 0, 0, 0);
    print_verdict();
  end
endmodule : rfs_supervisor_tb
